// File: uetc_ep.sv
`timescale 1ns/1ps
module uetc_ep
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic usb_rst,
  input wire logic sw_wr,
  input wire logic [7:0] sw_wdata,
  input wire uetc_pkg::uetc_token_t tok,
  input wire uetc_pkg::uetc_event_t ev,
  input wire logic sel,
  output logic [7:0] reg_val,
  output uetc_pkg::uetc_resp_t resp
);
  logic ctr_r;
  logic tog_r;
  logic [1:0] stat_r;
  logic [1:0] pid_r;
  logic cep_r;
  logic iso_r;
  logic [1:0] cur_pid_r;
  logic tok_hit;
  logic setup_ok;
  logic success;

  assign tok_hit = sel && tok.valid;
  // Successful transaction on this endpoint, kept from the latched token
  assign success = sel && !ev.err && (
    ((cur_pid_r == uetc_pkg::PID_IN) && (iso_r ? ev.tx_done : ev.ack_rcvd)) ||
    ((cur_pid_r != uetc_pkg::PID_IN) && ev.rx_ok));
  assign setup_ok = success && cep_r && (cur_pid_r == uetc_pkg::PID_SETUP);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_pid_r <= uetc_pkg::PID_OUT;
    else if (tok_hit)
      cur_pid_r <= tok.pid;
  end

  // Flag survives USB reset; hardware set wins over software clear, except on a non-iso endpoint whose flag is already set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctr_r <= 1'b0;
    else if (success && !(ctr_r && !iso_r))
      ctr_r <= 1'b1;
    else if (sw_wr && !sw_wdata[uetc_pkg::BIT_CTR])
      ctr_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pid_r <= uetc_pkg::PID_OUT;
    else if (usb_rst)
      pid_r <= uetc_pkg::PID_OUT;
    else if (tok_hit && !ctr_r)
      pid_r <= tok.pid;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tog_r <= 1'b0;
    else if (usb_rst)
      tog_r <= 1'b0;
    else if (tok_hit && cep_r && tok.pid == uetc_pkg::PID_SETUP)
      tog_r <= 1'b1;
    else if (sel && cur_pid_r == uetc_pkg::PID_IN && !ev.err &&
             (iso_r ? ev.tx_done : ev.ack_rcvd))
      tog_r <= ~tog_r;
    else if (sw_wr)
      tog_r <= sw_wdata[uetc_pkg::BIT_TOG];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_r <= uetc_pkg::STAT_DISABLED;
    else if (usb_rst)
      stat_r <= uetc_pkg::STAT_DISABLED;
    else if (success && !iso_r && (cur_pid_r == uetc_pkg::PID_IN || setup_ok))
      stat_r <= uetc_pkg::STAT_NAK;
    else if (sw_wr)
      stat_r <= sw_wdata[uetc_pkg::BIT_STAT_HI:uetc_pkg::BIT_STAT_LO];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cep_r <= 1'b0;
      iso_r <= 1'b0;
    end
    else if (usb_rst)
    begin
      cep_r <= 1'b0;
      iso_r <= 1'b0;
    end
    else if (sw_wr)
    begin
      cep_r <= sw_wdata[uetc_pkg::BIT_CEP];
      iso_r <= sw_wdata[uetc_pkg::BIT_ISO];
    end
  end

  assign reg_val = {ctr_r, tog_r, stat_r, pid_r, cep_r, iso_r};

  // Answer to the current token; endpoint select follows the live token, else the caller's latched endpoint
  always_comb
  begin
    resp = '{hs: uetc_pkg::HS_NONE, send_data: 1'b0, data1: 1'b0, use_rx_buf: 1'b0};
    resp.use_rx_buf = iso_r && tog_r;
    if (sel && cur_pid_r == uetc_pkg::PID_SETUP)
    begin
      if (cep_r && ev.rx_stat == uetc_pkg::STAT_NAK)
        resp.hs = uetc_pkg::HS_NONE;
      else if (cep_r && !ctr_r)
        resp.hs = uetc_pkg::HS_ACK;
      else
        resp.hs = uetc_pkg::HS_NONE;
    end
    else if (sel && cur_pid_r == uetc_pkg::PID_IN)
    begin
      if (iso_r)
      begin
        resp.send_data = (stat_r == uetc_pkg::STAT_VALID);
        resp.data1 = 1'b0;
      end
      else if (ctr_r && stat_r != uetc_pkg::STAT_DISABLED)
        resp.hs = uetc_pkg::HS_NAK;
      else
      begin
        unique case (stat_r)
          uetc_pkg::STAT_DISABLED: resp.hs = uetc_pkg::HS_NONE;
          uetc_pkg::STAT_STALL: resp.hs = uetc_pkg::HS_STALL;
          uetc_pkg::STAT_NAK: resp.hs = uetc_pkg::HS_NAK;
          uetc_pkg::STAT_VALID: resp.send_data = 1'b1;
        endcase
        resp.data1 = tog_r;
      end
    end
    else if (sel && cur_pid_r == uetc_pkg::PID_OUT && !iso_r && ctr_r &&
             stat_r != uetc_pkg::STAT_DISABLED)
      resp.hs = uetc_pkg::HS_NAK;
  end

  sequence s_in_ok;
    success && !iso_r && cur_pid_r == uetc_pkg::PID_IN && !usb_rst;
  endsequence

  sequence s_setup_tok;
    tok_hit && cep_r && tok.pid == uetc_pkg::PID_SETUP && !usb_rst;
  endsequence

  AST_TOG_ISO: assert property (@(posedge pclk) disable iff (!presetn)
    sel && iso_r && cur_pid_r == uetc_pkg::PID_IN && ev.tx_done && !ev.err && !usb_rst && !tok_hit
    |=> tog_r != $past(tog_r))
    else $error("iso toggle not inverted");
  AST_CTR_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    usb_rst && !sw_wr |=> ctr_r == $past(ctr_r))
    else $error("ctr changed by usb reset");
  AST_IN_NAK: assert property (@(posedge pclk) disable iff (!presetn)
    s_in_ok |=> stat_r == uetc_pkg::STAT_NAK)
    else $error("status not moved to nak");
  AST_SETUP_TOG: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_tok |=> tog_r)
    else $error("setup did not force toggle");
  AST_PID_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    ctr_r && !usb_rst |=> pid_r == $past(pid_r))
    else $error("token pid changed while flag set");
endmodule

// File: uetc_host_model.sv
`timescale 1ns/1ps
module uetc_host_model
(
  input wire logic pclk,
  output uetc_pkg::uetc_token_t tok,
  output uetc_pkg::uetc_event_t ev
);
  initial
  begin
    tok = '0;
    ev = '0;
  end
  // Stale token fields are inverted so a late sampler cannot pass by luck
  task automatic token(input logic [3:0] e, input logic [1:0] p);
    @(posedge pclk);
    tok <= '{1'b1, e, p};
    @(posedge pclk);
    tok <= '{1'b0, ~e, ~p};
  endtask
  task automatic rx_level(input logic [1:0] s);
    ev.rx_stat <= s;
  endtask
  // Order is rx_ok, tx_done, ack_rcvd, err
  task automatic pulse(input logic [3:0] f);
    @(posedge pclk);
    {ev.rx_ok, ev.tx_done, ev.ack_rcvd, ev.err} <= f;
    @(posedge pclk);
    {ev.rx_ok, ev.tx_done, ev.ack_rcvd, ev.err} <= 4'h0;
  endtask
endmodule

// File: uetc_pkg.sv
package uetc_pkg;
  localparam int NUM_EP = 16;
  localparam int EP_IDX_W = 4;
  localparam logic [11:0] EP_TX_BASE = 12'h0f0;
  // Placed above the last endpoint word, 0x12c, so the two maps never overlap
  localparam logic [11:0] CTRL_ADDR = 12'h130;
  localparam logic [11:0] STAT_ADDR = 12'h134;
  localparam logic [7:0] EP_TX_RESET = 8'h00;
  localparam int BIT_CTR = 7;
  localparam int BIT_TOG = 6;
  localparam int BIT_STAT_HI = 5;
  localparam int BIT_STAT_LO = 4;
  localparam int BIT_PID_HI = 3;
  localparam int BIT_PID_LO = 2;
  localparam int BIT_CEP = 1;
  localparam int BIT_ISO = 0;
  localparam int BIT_FORCE_USB_RESET = 0;
  localparam logic [1:0] STAT_DISABLED = 2'h0;
  localparam logic [1:0] STAT_STALL = 2'h1;
  localparam logic [1:0] STAT_NAK = 2'h2;
  localparam logic [1:0] STAT_VALID = 2'h3;
  localparam logic [1:0] PID_OUT = 2'h0;
  localparam logic [1:0] PID_IN = 2'h2;
  localparam logic [1:0] PID_SETUP = 2'h3;
  localparam logic [31:0] ERR_DATA = 32'h0000_0000;

  typedef enum logic [1:0] {
    HS_NONE,
    HS_ACK,
    HS_NAK,
    HS_STALL
  } uetc_hs_t;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    logic [1:0] pid;
  } uetc_token_t;

  typedef struct packed {
    logic [1:0] rx_stat;
    logic rx_ok;
    logic tx_done;
    logic ack_rcvd;
    logic err;
  } uetc_event_t;

  typedef struct packed {
    uetc_hs_t hs;
    logic send_data;
    logic data1;
    logic use_rx_buf;
  } uetc_resp_t;
endpackage

// File: uetc_top.sv
`timescale 1ns/1ps
module uetc_top
#(
  parameter int NUM_EP = uetc_pkg::NUM_EP
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_reset_in,
  input wire uetc_pkg::uetc_token_t tok,
  input wire uetc_pkg::uetc_event_t ev,
  output uetc_pkg::uetc_resp_t resp,
  output logic usb_reset_event
);
  // Endpoint index and decode are four bits wide, so only sixteen fit
  if (NUM_EP != uetc_pkg::NUM_EP)
  begin : g_num_ep_check
    $error("NUM_EP must be 16");
  end

  logic bus_rst_m_r;
  logic bus_rst_r;
  logic force_usb_reset_r;
  logic usb_rst;
  logic usb_rst_d_r;
  logic [3:0] cur_ep_r;
  logic wr_en;
  logic rd_en;
  logic [4:0] addr_hit;
  logic [7:0] reg_val [NUM_EP];
  uetc_pkg::uetc_resp_t ep_resp [NUM_EP];
  logic [31:0] prdata_r;
  logic pslverr_r;

  // Returns endpoint index and hit for an address
  function automatic logic [4:0] ep_dec(input logic [11:0] a);
    logic [11:0] d;
    d = a - uetc_pkg::EP_TX_BASE;
    if (a >= uetc_pkg::EP_TX_BASE && d[11:6] == 6'h00 && d[1:0] == 2'h0)
      ep_dec = {1'b1, d[5:2]};
    else
      ep_dec = 5'h00;
  endfunction

  // Bus-reset pin crosses from the line side
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_rst_m_r <= 1'b0;
      bus_rst_r <= 1'b0;
    end
    else
    begin
      bus_rst_m_r <= bus_reset_in;
      bus_rst_r <= bus_rst_m_r;
    end
  end

  assign usb_rst = bus_rst_r || force_usb_reset_r;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_hit = ep_dec(paddr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      force_usb_reset_r <= 1'b0;
    else if (wr_en && paddr == uetc_pkg::CTRL_ADDR)
      force_usb_reset_r <= pwdata[uetc_pkg::BIT_FORCE_USB_RESET];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      usb_rst_d_r <= 1'b0;
    else
      usb_rst_d_r <= usb_rst;
  end

  assign usb_reset_event = usb_rst && !usb_rst_d_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_ep_r <= 4'h0;
    else if (tok.valid)
      cur_ep_r <= tok.ep;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++)
    begin : g_ep
      logic [4:0] hit;
      logic sel_g;
      assign hit = ep_dec(paddr);
      assign sel_g = tok.valid ? (tok.ep == 4'(g)) : (cur_ep_r == 4'(g));
      uetc_ep u_ep
      (
        .pclk(pclk),
        .presetn(presetn),
        .usb_rst(usb_rst),
        .sw_wr(wr_en && hit[4] && hit[3:0] == 4'(g)),
        .sw_wdata(pwdata[7:0]),
        .tok(tok),
        .ev(ev),
        .sel(sel_g),
        .reg_val(reg_val[g]),
        .resp(ep_resp[g])
      );
    end
  endgenerate

  assign resp = ep_resp[cur_ep_r];

  // Read data latched in setup phase so it stands steady through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= uetc_pkg::ERR_DATA;
      pslverr_r <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr_r <= !addr_hit[4] && paddr != uetc_pkg::CTRL_ADDR && paddr != uetc_pkg::STAT_ADDR;
      if (!rd_en)
        prdata_r <= uetc_pkg::ERR_DATA;
      else if (addr_hit[4])
        prdata_r <= {24'h000000, reg_val[addr_hit[3:0]]};
      else if (paddr == uetc_pkg::CTRL_ADDR)
        prdata_r <= {31'h00000000, force_usb_reset_r};
      else if (paddr == uetc_pkg::STAT_ADDR)
        prdata_r <= {27'h0000000, usb_rst, cur_ep_r};
      else
        prdata_r <= uetc_pkg::ERR_DATA;
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = psel && penable && pslverr_r;

  // A forced reset inside a bus reset is one reset, so it raises no second event
  AST_RST_EVT: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(force_usb_reset_r) && !$past(bus_rst_r) |-> usb_reset_event)
    else $error("reset event missing");
  AST_EP_RST: assert property (@(posedge pclk) disable iff (!presetn)
    $past(usb_rst) && !$past(tok.valid) |-> reg_val[0][6:0] == 7'h00)
    else $error("endpoint not cleared");
endmodule

// File: usb_endpoint_tx_control_tb_top.sv
`timescale 1ns/1ps
module usb_endpoint_tx_control_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic bus_reset_in = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic usb_reset_event;
  uetc_pkg::uetc_token_t tok;
  uetc_pkg::uetc_event_t ev;
  uetc_pkg::uetc_resp_t resp;
  int errors = 0;
  int checked = 0;
  int nev = 0;
  logic [31:0] rdat;
  logic rerr;
  always #12.5 pclk = ~pclk;
  uetc_top dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_reset_in(bus_reset_in), .tok(tok), .ev(ev), .resp(resp), .usb_reset_event(usb_reset_event));
  uetc_host_model host(.pclk(pclk), .tok(tok), .ev(ev));
  always @(posedge pclk)
    if (usb_reset_event === 1'b1)
      nev++;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] ea(input int n);
    return uetc_pkg::EP_TX_BASE + 12'(4 * n);
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rdat, {24'h0, e});
  endtask
  // Response is {hs, send_data, data1, use_rx_buf}
  task automatic tk(input string n, input logic [3:0] e, input logic [1:0] p, input logic [4:0] x);
    host.token(e, p);
    #1;
    chk(n, {27'h0, resp}, {27'h0, x});
  endtask
  task automatic t_reset;
    rd("ep0", ea(0), 8'h00);
    rd("ep15", ea(15), 8'h00);
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped", {31'h0, rerr}, 32'h1);
  endtask
  task automatic t_in;
    wr(ea(1), 8'h30);
    tk("in_resp", 4'h1, uetc_pkg::PID_IN, 5'h04);
    host.pulse(4'h2);
    rd("in_done", ea(1), 8'he8);
    // OUT token would rewrite the pid field if it were not frozen
    tk("flow_nak", 4'h1, uetc_pkg::PID_OUT, 5'h10);
    rd("pid_frozen", ea(1), 8'he8);
    wr(ea(1), 8'hc0);
    rd("wr_one", ea(1), 8'hc8);
    wr(ea(1), 8'h4c);
    rd("clear", ea(1), 8'h48);
  endtask
  task automatic t_stat;
    logic [4:0] x [4] = '{5'h00, 5'h18, 5'h10, 5'h04};
    for (int s = 0; s < 4; s++)
    begin
      wr(ea(4), {2'b00, 2'(s), 4'h0});
      tk("stat", 4'h4, uetc_pkg::PID_IN, x[s]);
    end
    // Ack together with an error must not count as a correct transfer
    host.pulse(4'h3);
    rd("err_no_ctr", ea(4), 8'h38);
  endtask
  task automatic t_ctrl;
    host.rx_level(uetc_pkg::STAT_STALL);
    wr(ea(0), 8'h02);
    tk("setup_ack", 4'h0, uetc_pkg::PID_SETUP, 5'h08);
    host.pulse(4'h8);
    rd("setup", ea(0), 8'hee);
    wr(ea(0), 8'h02);
    host.rx_level(uetc_pkg::STAT_NAK);
    tk("setup_nak", 4'h0, uetc_pkg::PID_SETUP, 5'h00);
  endtask
  task automatic t_iso;
    wr(ea(2), 8'h31);
    tk("iso_a", 4'h2, uetc_pkg::PID_IN, 5'h04);
    host.pulse(4'h4);
    rd("iso_done", ea(2), 8'hf9);
    tk("iso_b", 4'h2, uetc_pkg::PID_IN, 5'h05);
  endtask
  task automatic t_rst;
    @(posedge pclk);
    bus_reset_in <= 1'b1;
    repeat (6) @(posedge pclk);
    bus_reset_in <= 1'b0;
    repeat (4) @(posedge pclk);
    rd("bus_rst", ea(2), 8'h80);
    wr(ea(3), 8'h30);
    wr(uetc_pkg::CTRL_ADDR, 8'h01);
    repeat (4) @(posedge pclk);
    apb(1'b0, uetc_pkg::STAT_ADDR, 32'h0);
    chk("rst_active", rdat, 32'h12);
    rd("frc_rst", ea(3), 8'h00);
    wr(ea(3), 8'h30);
    rd("held", ea(3), 8'h00);
    wr(uetc_pkg::CTRL_ADDR, 8'h00);
    chk("rst_events", nev, 32'h2);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    finish_test;
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_in;
    t_stat;
    t_ctrl;
    t_iso;
    t_rst;
    finish_test;
  end
endmodule
